// *** uecr_pkg.sv ***
// shared constants and types of the usb endpoint control register block
package uecr_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_SETUP_BASE = 16'h0CE8;
  localparam logic [15:0] IDX_TOGGLE_CTL = 16'hC7D7;
  localparam logic [15:0] IDX_FRAME_LOW = 16'hC7D8;
  localparam logic [15:0] IDX_FRAME_HIGH = 16'hC7D9;
  localparam logic [15:0] IDX_DEV_ADDR = 16'hC7DB;
  localparam logic [15:0] IDX_EP_PAIRING = 16'hC7DD;
  localparam logic [15:0] IDX_IN_ACTIVE = 16'hC7DE;
  localparam logic [15:0] IDX_OUT_ACTIVE = 16'hC7DF;
  localparam logic [15:0] IDX_ISO_IN_ACTIVE = 16'hC7E0;
  localparam logic [15:0] IDX_ISO_OUT_ACTIVE = 16'hC7E1;
  localparam logic [15:0] IDX_ISO_OUT_START = 16'hC7F0;
  localparam logic [15:0] IDX_ISO_IN_START = 16'hC7F8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TGL_VALUE_BIT = 7;
  localparam int TGL_SET_BIT = 6;
  localparam int TGL_CLR_BIT = 5;
  localparam int TGL_DIR_BIT = 4;
  localparam int ZERO_LEN_BIT = 7;
  localparam int START_LSB = 2;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int EP_COUNT = 6;
  localparam logic [3:0] ISO_EP_NUM = 4'h8;
  localparam logic [2:0] EP_NUM_MAX = 3'h5;
  localparam logic [7:0] PAIRING_MASK = 8'h9F;
  localparam logic [5:0] ACTIVE_RESET = 6'h01;
  localparam logic [6:0] DEV_ADDR_RESET = 7'h00;

  typedef struct packed {
    logic dirIn;
    logic [3:0] num;
  } uecr_ep_t;

  typedef struct packed {
    logic [6:0] addr;
    uecr_ep_t ep;
  } uecr_token_t;

  typedef struct packed {
    logic respond;
    logic zeroLen;
    logic toggle;
  } uecr_verdict_t;

endpackage

// *** uecr_top.sv ***
// usb endpoint control and status registers with avalon-mm slave
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module uecr_top
  import uecr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sofValid,
  input wire logic [10:0] sofFrame,
  input wire logic addrSetValid,
  input wire logic [6:0] addrSetValue,
  input wire logic setupByteValid,
  input wire logic [2:0] setupByteIndex,
  input wire logic [7:0] setupByteData,
  input wire logic tokenValid,
  input wire uecr_token_t token,
  input wire logic isoInFifoEmpty,
  input wire logic toggleFlip,
  input wire uecr_ep_t toggleEp,
  output uecr_verdict_t verdict,
  output logic [4:0] pairing,
  output logic [9:0] isoOutStart,
  output logic [9:0] isoInStart
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] tglIndex(input logic dirIn, input logic [2:0] num);
    tglIndex = dirIn ? 4'(num) + 4'h6 : 4'(num);
  endfunction

  logic [5:0] inActive;
  logic [5:0] outActive;
  logic isoInActive;
  logic isoOutActive;

  function automatic logic epActive(input uecr_ep_t ep, input logic [5:0] inAct,
                                    input logic [5:0] outAct, input logic isoIn,
                                    input logic isoOut);
    if (ep.num == ISO_EP_NUM) begin
      epActive = ep.dirIn ? isoIn : isoOut;
    end else if (ep.num <= 4'(EP_NUM_MAX)) begin
      epActive = ep.dirIn ? inAct[ep.num[2:0]] : outAct[ep.num[2:0]];
    end else begin
      epActive = 1'b0;
    end
  endfunction

  // ----------------------------------------------------------------
  // avalon slave handshake
  // ----------------------------------------------------------------
  // fixed one wait state: request seen, answer prepared, then released
  logic busReq;
  logic busAck;
  logic [15:0] regIdx;
  logic wrEn;
  logic [7:0] readMux;

  assign busReq = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~busAck;
  assign regIdx = avs_address[17:2];
  assign wrEn = avs_write & busAck & avs_byteenable[0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busAck <= 1'b0;
    end else begin
      busAck <= busReq & ~busAck;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !busAck) begin
      avs_readdata <= {24'h00_0000, readMux};
    end
  end

  // ----------------------------------------------------------------
  // toggle control
  // ----------------------------------------------------------------
  logic [2:0] selNum;
  logic selDirIn;
  logic [11:0] toggles;
  logic tglWr;
  logic tglSet;
  logic tglClr;
  logic [2:0] wrNum;
  logic wrDirIn;
  logic wrSelValid;
  logic [3:0] wrSelIdx;
  logic selQ;

  assign tglWr = wrEn && (regIdx == IDX_TOGGLE_CTL);
  assign tglSet = tglWr & avs_writedata[TGL_SET_BIT];
  assign tglClr = tglWr & avs_writedata[TGL_CLR_BIT];
  assign wrNum = avs_writedata[2:0];
  assign wrDirIn = avs_writedata[TGL_DIR_BIT];
  // strobes act on the selector carried in the same write
  assign wrSelValid = (wrNum <= EP_NUM_MAX);
  assign wrSelIdx = tglIndex(wrDirIn, wrNum);
  // out-of-range selector reads DATA0 rather than a stray bit
  assign selQ = (selNum <= EP_NUM_MAX) ? toggles[tglIndex(selDirIn, selNum)] : 1'b0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      selNum <= 3'h0;
      selDirIn <= 1'b0;
    end else if (tglWr) begin
      selNum <= wrNum;
      selDirIn <= wrDirIn;
    end
  end

  generate
    for (genvar j = 0; j < 2 * EP_COUNT; j++) begin : g_toggle
      localparam logic JIN = (j >= EP_COUNT);
      localparam logic [2:0] JNUM = 3'(j % EP_COUNT);
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          toggles[j] <= 1'b0;
        end else if ((tglSet || tglClr) && wrSelValid && wrSelIdx == 4'(j)) begin
          toggles[j] <= ~tglClr;
        end else if (toggleFlip && toggleEp.dirIn == JIN && toggleEp.num == {1'b0, JNUM}) begin
          toggles[j] <= ~toggles[j];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // frame count and function address
  // ----------------------------------------------------------------
  logic [10:0] frameCount;
  logic [6:0] deviceAddress;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frameCount <= 11'h000;
    end else if (sofValid) begin
      frameCount <= sofFrame;
    end
  end

  // address zero is never taken; it is the default before enumeration
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      deviceAddress <= DEV_ADDR_RESET;
    end else if (addrSetValid && addrSetValue != 7'h00) begin
      deviceAddress <= addrSetValue;
    end
  end

  // ----------------------------------------------------------------
  // software configuration registers
  // ----------------------------------------------------------------
  logic [7:0] pairingReg;
  logic [5:0] isoOutStartReg;
  logic [5:0] isoInStartReg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pairingReg <= 8'h00;
    end else if (wrEn && regIdx == IDX_EP_PAIRING) begin
      pairingReg <= avs_writedata[7:0] & PAIRING_MASK;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      inActive <= ACTIVE_RESET;
      outActive <= ACTIVE_RESET;
      isoInActive <= 1'b0;
      isoOutActive <= 1'b0;
    end else if (wrEn) begin
      if (regIdx == IDX_IN_ACTIVE) begin
        inActive <= avs_writedata[5:0];
      end
      if (regIdx == IDX_OUT_ACTIVE) begin
        outActive <= avs_writedata[5:0];
      end
      if (regIdx == IDX_ISO_IN_ACTIVE) begin
        isoInActive <= avs_writedata[0];
      end
      if (regIdx == IDX_ISO_OUT_ACTIVE) begin
        isoOutActive <= avs_writedata[0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      isoOutStartReg <= 6'h00;
      isoInStartReg <= 6'h00;
    end else if (wrEn) begin
      if (regIdx == IDX_ISO_OUT_START) begin
        isoOutStartReg <= avs_writedata[7:START_LSB];
      end
      if (regIdx == IDX_ISO_IN_START) begin
        isoInStartReg <= avs_writedata[7:START_LSB];
      end
    end
  end

  assign pairing = pairingReg[4:0];
  assign isoOutStart = {isoOutStartReg, 4'h0};
  assign isoInStart = {isoInStartReg, 4'h0};

  // ----------------------------------------------------------------
  // setup packet buffer
  // ----------------------------------------------------------------
  logic [7:0] setupBuf [8];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < 8; k++) begin
        setupBuf[k] <= 8'h00;
      end
    end else if (setupByteValid) begin
      setupBuf[setupByteIndex] <= setupByteData;
    end
  end

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    readMux = 8'h00;
    if (regIdx[15:3] == IDX_SETUP_BASE[15:3]) begin
      readMux = setupBuf[regIdx[2:0]];
    end else begin
      unique case (regIdx)
        IDX_TOGGLE_CTL: readMux = {selQ, 2'b00, selDirIn, 1'b0, selNum};
        IDX_FRAME_LOW: readMux = frameCount[7:0];
        IDX_FRAME_HIGH: readMux = {5'h00, frameCount[10:8]};
        IDX_DEV_ADDR: readMux = {1'b0, deviceAddress};
        IDX_EP_PAIRING: readMux = pairingReg;
        IDX_IN_ACTIVE: readMux = {2'b00, inActive};
        IDX_OUT_ACTIVE: readMux = {2'b00, outActive};
        IDX_ISO_IN_ACTIVE: readMux = {7'h00, isoInActive};
        IDX_ISO_OUT_ACTIVE: readMux = {7'h00, isoOutActive};
        IDX_ISO_OUT_START: readMux = {isoOutStartReg, 2'b00};
        IDX_ISO_IN_START: readMux = {isoInStartReg, 2'b00};
        default: readMux = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // token verdict toward the protocol engine
  // ----------------------------------------------------------------
  logic addrMatch;
  logic tokActive;
  logic isoInTok;
  logic tokToggle;

  assign addrMatch = (token.addr == deviceAddress);
  assign tokActive = epActive(token.ep, inActive, outActive, isoInActive, isoOutActive);
  assign isoInTok = token.ep.dirIn && token.ep.num == ISO_EP_NUM;
  assign tokToggle = (token.ep.num <= 4'(EP_NUM_MAX)) ?
                     toggles[tglIndex(token.ep.dirIn, token.ep.num[2:0])] : 1'b0;

  // verdict is a one-cycle pulse one edge after the token strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      verdict <= '0;
    end else begin
      verdict <= '0;
      if (tokenValid && addrMatch && tokActive) begin
        if (isoInTok && isoInFifoEmpty) begin
          verdict.respond <= pairingReg[ZERO_LEN_BIT];
          verdict.zeroLen <= pairingReg[ZERO_LEN_BIT];
        end else begin
          verdict.respond <= 1'b1;
          verdict.toggle <= tokToggle;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_toggle_set_one: assert property (
    tglSet && !tglClr && wrSelValid |=> toggles[$past(wrSelIdx)])
    else $error("set strobe did not force DATA1");

  a_toggle_clear_wins: assert property (
    tglClr && wrSelValid |=> !toggles[$past(wrSelIdx)])
    else $error("clear strobe did not force DATA0");

  a_toggle_read_back: assert property (
    avs_read && !busAck && regIdx == IDX_TOGGLE_CTL |=>
      avs_readdata[TGL_VALUE_BIT] == $past(selQ) && avs_readdata[6:5] == 2'b00)
    else $error("toggle value read back wrong");

  a_frame_capture: assert property (
    sofValid |=> frameCount == $past(sofFrame) ##1
      ($past(sofValid) || frameCount == $past(sofFrame, 2)))
    else $error("frame number not captured");

  a_addr_capture: assert property (
    addrSetValid && addrSetValue != 7'h00 |=> deviceAddress == $past(addrSetValue))
    else $error("function address not stored");

  a_addr_filter: assert property (
    tokenValid && !addrMatch |=> !verdict.respond && !verdict.zeroLen)
    else $error("token to foreign address answered");

  a_inactive_silent: assert property (
    tokenValid && !tokActive |=> !verdict.respond)
    else $error("inactive endpoint answered");

  a_iso_zero_len: assert property (
    tokenValid && addrMatch && tokActive && isoInTok && isoInFifoEmpty &&
      pairingReg[ZERO_LEN_BIT] |=> verdict.respond && verdict.zeroLen)
    else $error("zero-length reply missing");

  a_iso_no_reply: assert property (
    tokenValid && isoInTok && isoInFifoEmpty && !pairingReg[ZERO_LEN_BIT] |=>
      !verdict.respond)
    else $error("empty iso IN answered without policy");

  a_start_low_bits: assert property (
    avs_read && !busAck && (regIdx == IDX_ISO_OUT_START || regIdx == IDX_ISO_IN_START)
      |=> avs_readdata[1:0] == 2'b00)
    else $error("start address low bits not zero");

  a_bus_one_wait: assert property (
    busReq && !busAck |=> !avs_waitrequest ##1 !busAck)
    else $error("slave did not answer after one wait state");

  c_toggle_set: cover property (tglSet ##1 avs_read && regIdx == IDX_TOGGLE_CTL);
  c_zero_len: cover property (verdict.zeroLen);
  c_token_answer: cover property (sofValid ##[1:20] verdict.respond);

endmodule

`default_nettype wire

// *** uecr_host_model.sv ***
// bus-side engine model feeding packet events and tokens into the block
`timescale 1ns/100ps
`default_nettype none

module uecr_host_model
  import uecr_pkg::*;
(
  input wire logic clk,
  output logic sofValid,
  output logic [10:0] sofFrame,
  output logic addrSetValid,
  output logic [6:0] addrSetValue,
  output logic setupByteValid,
  output logic [2:0] setupByteIndex,
  output logic [7:0] setupByteData,
  output logic tokenValid,
  output var uecr_token_t token,
  output logic isoInFifoEmpty,
  output logic toggleFlip,
  output var uecr_ep_t toggleEp,
  input wire uecr_verdict_t verdict
);
  initial begin
    {sofValid, addrSetValid, setupByteValid, tokenValid, toggleFlip} = 5'h00;
    {sofFrame, addrSetValue, setupByteIndex, setupByteData, token, toggleEp} = '0;
    isoInFifoEmpty = 1'b0;
  end

  // data fields except setupByteIndex and isoInFifoEmpty go to the inverse once a strobe is over, never a stale copy
  task automatic sof(input logic [10:0] f);
    sofFrame <= f;
    sofValid <= 1'b1;
    @(posedge clk);
    sofValid <= 1'b0;
    sofFrame <= ~f;
  endtask

  task automatic setAddr(input logic [6:0] a);
    addrSetValue <= a;
    addrSetValid <= 1'b1;
    @(posedge clk);
    addrSetValid <= 1'b0;
    addrSetValue <= ~a;
  endtask

  task automatic setupByte(input logic [2:0] i, input logic [7:0] d);
    setupByteIndex <= i;
    setupByteData <= d;
    setupByteValid <= 1'b1;
    @(posedge clk);
    setupByteValid <= 1'b0;
    setupByteData <= ~d;
  endtask

  task automatic flip(input uecr_ep_t ep);
    toggleEp <= ep;
    toggleFlip <= 1'b1;
    @(posedge clk);
    toggleFlip <= 1'b0;
    toggleEp <= ~ep;
  endtask

  // verdict is a one-cycle pulse, so it is caught mid-cycle after the token
  task automatic tok(input uecr_token_t t, input logic emp, output uecr_verdict_t v);
    token <= t;
    isoInFifoEmpty <= emp;
    tokenValid <= 1'b1;
    @(posedge clk);
    tokenValid <= 1'b0;
    token <= ~t;
    @(negedge clk);
    v = verdict;
    @(posedge clk);
  endtask
endmodule

`default_nettype wire

// *** tb_usb_endpoint_control_regs.sv ***
// self-checking testbench of the usb endpoint control register block
`timescale 1ns/100ps
`default_nettype none

module tb_usb_endpoint_control_regs
  import uecr_pkg::*;
;
  logic clk, nrst, avs_read, avs_write, avs_waitrequest;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic sofValid, addrSetValid, setupByteValid, tokenValid, isoInFifoEmpty, toggleFlip;
  logic [10:0] sofFrame;
  logic [6:0] addrSetValue;
  logic [2:0] setupByteIndex;
  logic [7:0] setupByteData;
  uecr_token_t token;
  uecr_ep_t toggleEp;
  uecr_verdict_t verdict;
  logic [4:0] pairing;
  logic [9:0] isoOutStart, isoInStart;
  int mismatches = 0;
  int compares = 0;
  localparam logic [6:0] ADR = 7'h2A;

  uecr_top uut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sofValid(sofValid),
    .sofFrame(sofFrame), .addrSetValid(addrSetValid), .addrSetValue(addrSetValue),
    .setupByteValid(setupByteValid), .setupByteIndex(setupByteIndex),
    .setupByteData(setupByteData), .tokenValid(tokenValid), .token(token),
    .isoInFifoEmpty(isoInFifoEmpty), .toggleFlip(toggleFlip), .toggleEp(toggleEp),
    .verdict(verdict), .pairing(pairing), .isoOutStart(isoOutStart), .isoInStart(isoInStart));

  uecr_host_model uHost (.clk(clk), .sofValid(sofValid), .sofFrame(sofFrame),
    .addrSetValid(addrSetValid), .addrSetValue(addrSetValue), .setupByteValid(setupByteValid),
    .setupByteIndex(setupByteIndex), .setupByteData(setupByteData), .tokenValid(tokenValid),
    .token(token), .isoInFifoEmpty(isoInFifoEmpty), .toggleFlip(toggleFlip),
    .toggleEp(toggleEp), .verdict(verdict));

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // waitrequest is read at the rising edge, before that edge's own updates land
  task automatic busCycle(input logic [15:0] idx, input logic w, input logic [7:0] d,
                          input logic [3:0] be, output logic [31:0] r);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] r;
    busCycle(idx, 1'b1, d, 4'hF, r);
  endtask

  task automatic rdChk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    busCycle(idx, 1'b0, 8'h00, 4'hF, r);
    chk(r, exp);
  endtask

  task automatic tokChk(input logic [6:0] a, input logic dirIn, input logic [3:0] n,
                        input logic emp, input logic [2:0] exp);
    uecr_verdict_t v;
    uHost.tok({a, dirIn, n}, emp, v);
    chk({29'h0, v}, {29'h0, exp});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic testReset();
    rdChk(IDX_TOGGLE_CTL, 32'h0);
    rdChk(IDX_IN_ACTIVE, {26'h0, ACTIVE_RESET});
    rdChk(IDX_OUT_ACTIVE, {26'h0, ACTIVE_RESET});
    rdChk(IDX_ISO_IN_ACTIVE, 32'h0);
    rdChk(IDX_ISO_OUT_ACTIVE, 32'h0);
    rdChk(IDX_DEV_ADDR, 32'h0);
  endtask

  task automatic testToggle();
    logic [7:0] sel;
    for (int d = 0; d < 2; d++) begin
      for (int n = 0; n <= 5; n++) begin
        sel = {3'h0, d[0], 1'b0, n[2:0]};
        wr(IDX_TOGGLE_CTL, sel | 8'h40);
        rdChk(IDX_TOGGLE_CTL, {24'h0, sel | 8'h80});
        wr(IDX_TOGGLE_CTL, sel | 8'h60);
        rdChk(IDX_TOGGLE_CTL, {24'h0, sel});
      end
    end
    wr(IDX_TOGGLE_CTL, 8'h53);
    wr(IDX_TOGGLE_CTL, 8'h03);
    rdChk(IDX_TOGGLE_CTL, 32'h03);
    wr(IDX_TOGGLE_CTL, 8'h13);
    rdChk(IDX_TOGGLE_CTL, 32'h93);
    wr(IDX_TOGGLE_CTL, 8'h33);
  endtask

  task automatic testFrame();
    uHost.sof(11'h7FF);
    rdChk(IDX_FRAME_LOW, 32'hFF);
    rdChk(IDX_FRAME_HIGH, 32'h07);
    wr(IDX_FRAME_LOW, 8'h12);
    rdChk(IDX_FRAME_LOW, 32'hFF);
    uHost.sof(11'h000);
    rdChk(IDX_FRAME_HIGH, 32'h0);
  endtask

  task automatic testAddress();
    tokChk(7'h00, 1'b0, 4'h0, 1'b0, 3'b100);
    uHost.setAddr(ADR);
    rdChk(IDX_DEV_ADDR, {25'h0, ADR});
    uHost.setAddr(7'h00);
    wr(IDX_DEV_ADDR, 8'h11);
    rdChk(IDX_DEV_ADDR, {25'h0, ADR});
    tokChk(7'h2B, 1'b0, 4'h0, 1'b0, 3'b000);
    tokChk(7'h00, 1'b0, 4'h0, 1'b0, 3'b000);
    uHost.flip(5'h00);
    tokChk(ADR, 1'b0, 4'h0, 1'b0, 3'b101);
  endtask

  task automatic testActive();
    wr(IDX_OUT_ACTIVE, 8'h00);
    tokChk(ADR, 1'b0, 4'h0, 1'b0, 3'b000);
    wr(IDX_IN_ACTIVE, 8'h08);
    tokChk(ADR, 1'b1, 4'h3, 1'b0, 3'b100);
    tokChk(ADR, 1'b1, 4'h0, 1'b0, 3'b000);
    tokChk(ADR, 1'b0, ISO_EP_NUM, 1'b0, 3'b000);
    wr(IDX_ISO_OUT_ACTIVE, 8'h01);
    tokChk(ADR, 1'b0, ISO_EP_NUM, 1'b0, 3'b100);
    tokChk(ADR, 1'b1, ISO_EP_NUM, 1'b0, 3'b000);
    wr(IDX_ISO_IN_ACTIVE, 8'h01);
    tokChk(ADR, 1'b1, ISO_EP_NUM, 1'b0, 3'b100);
    tokChk(ADR, 1'b1, ISO_EP_NUM, 1'b1, 3'b000);
    wr(IDX_EP_PAIRING, 8'h80);
    tokChk(ADR, 1'b1, ISO_EP_NUM, 1'b1, 3'b110);
  endtask

  task automatic testPairing();
    for (int b = 0; b < 5; b++) begin
      wr(IDX_EP_PAIRING, 8'(1 << b));
      chk({27'h0, pairing}, 32'(1 << b));
    end
    wr(IDX_EP_PAIRING, 8'hFF);
    rdChk(IDX_EP_PAIRING, 32'h9F);
  endtask

  task automatic testSetupStarts();
    logic [31:0] r;
    for (int i = 0; i < 8; i++) begin
      uHost.setupByte(i[2:0], 8'hA0 + 8'(i));
      @(posedge clk);
    end
    for (int i = 0; i < 8; i++) begin
      rdChk(IDX_SETUP_BASE + 16'(i), 32'hA0 + 32'(i));
    end
    wr(IDX_ISO_OUT_START, 8'hFF);
    rdChk(IDX_ISO_OUT_START, 32'hFC);
    chk({22'h0, isoOutStart}, 32'h3F0);
    wr(IDX_ISO_IN_START, 8'hA7);
    busCycle(IDX_ISO_IN_START, 1'b1, 8'h00, 4'hE, r);
    rdChk(IDX_ISO_IN_START, 32'hA4);
    chk({22'h0, isoInStart}, 32'h290);
    rdChk(16'h0100, 32'h0);
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // about 95 bus cycles (some 340 clocks) are expected; the limit of 20000 clocks is far beyond that
  initial begin
    #(25 * 20000);
    mismatches++;
    print_verdict();
  end

  initial begin
    nrst = 1'b0;
    {avs_read, avs_write} = 2'b00;
    avs_address = 18'h00000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    testReset();
    testToggle();
    testFrame();
    testAddress();
    testActive();
    testPairing();
    testSetupStarts();
    print_verdict();
  end
endmodule

`default_nettype wire
